//--- src/dca_defs.vh
// constants for the converter clear and alarm control block
// assumes a single 25 MHz clock and twelve 12-bit converter channels
//
// Contract
// - clear low loads latches with clear code
// - clear never alters held data registers
// - release reloads latches from held data
// - clear high: latches follow normal load
// - alarm low when any channel out of range
// - alarm is open drain, never driven high
`ifndef DCA_DEFS_VH
`define DCA_DEFS_VH
`define DCA_CHANNELS      12
`define DCA_DATA_W        12
`define DCA_MON_CHANNELS  16
`define DCA_CLEAR_CODE    12'h000
`define DCA_DATA_RESET    12'h000
`endif

//--- src/dca_hold_mem.v
// held data registers for all converter channels, one word per channel
// assumes write port driven by the serial register logic outside this block
`include "dca_defs.vh"
`default_nettype none
module dca_hold_mem (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        wr_en,
	input  wire [3:0]  wr_addr,
	input  wire [11:0] wr_data,
	input  wire [3:0]  rd_addr,
	output reg  [11:0] rd_data
);
	reg [11:0] mem [0:`DCA_CHANNELS-1];
	integer    i;

	// writes come only from the host side; clear has no path here
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < `DCA_CHANNELS; i = i + 1)
				mem[i] <= `DCA_DATA_RESET;
			rd_data <= `DCA_DATA_RESET;
		end else begin
			if (wr_en && wr_addr < `DCA_CHANNELS)
				mem[wr_addr] <= wr_data;
			if (rd_addr < `DCA_CHANNELS)
				rd_data <= mem[rd_addr];
			else
				rd_data <= `DCA_DATA_RESET;
		end
	end
endmodule
`default_nettype wire

//--- src/dca_ctrl.v
// converter clear and global alarm control
// assumes inputs synchronous to clk except converter_clear_n, a board pin
`include "dca_defs.vh"
`default_nettype none
module dca_ctrl (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         converter_clear_n,
	input  wire         wr_en,
	input  wire [3:0]   wr_addr,
	input  wire [11:0]  wr_data,
	input  wire         sync_load_select,
	input  wire         load_pulse,
	input  wire [15:0]  out_of_range,
	output reg  [143:0] latch_flat,
	output reg          clear_active,
	output reg          alarm_out,
	output reg          alarm_oe_n
);
	// timing at a glance, counted in clk edges from the pin change:
	//   pin low  -> clr_meta low at 1, clr_sync low at 2
	//   clr_sync low -> every latch holds the clear code at 3
	//   the clear code stands for as long as clr_sync stays low
	//   pin high -> clr_sync high at 2, state leaves clear at 3
	//   reload waits for slot 0 of the scan, then walks 0..11
	//   worst-case reload ends about 27 edges after the pin rises
	//   normal update lands within 13 edges of a load, or of a write while sync_load_select is low
	// hazards kept in mind:
	//   the pin is asynchronous, so only clr_sync is ever read
	//   held data never see the clear path (no write port here)
	//   a clear that comes back during reload restarts the clear
	//   write addresses 12..15 map to no converter channel; the scan wraps after 11
	// limitation: one word read per cycle keeps the memory small
	// but makes a full sweep cost twelve cycles
	localparam [2:0] ST_RUN    = 3'h1;
	localparam [2:0] ST_CLEAR  = 3'h2;
	localparam [2:0] ST_RELOAD = 3'h4;

	reg        clr_meta;
	reg        clr_sync;
	reg [2:0]  state;
	reg [3:0]  scan;
	reg [3:0]  scan_d;
	reg        scan_valid;
	reg        reload_d;
	reg        reload_on;
	reg [11:0] pend_mask;
	wire [11:0] rd_data;

	// true for a scan or write slot that maps to a real channel
	function is_chan;
		input [3:0] idx;
		begin
			is_chan = (idx < 4'hC);
		end
	endfunction

	dca_hold_mem u_mem (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_addr (scan),
		.rd_data (rd_data)
	);

	// two-flop synchroniser on the clear pin
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clr_meta <= 1'b1;
			clr_sync <= 1'b1;
		end else begin
			clr_meta <= converter_clear_n;
			clr_sync <= clr_meta;
		end
	end

	// state: normal, held in clear, reloading latches after release
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_RUN;
		end else begin
			case (state)
			ST_RUN:    if (!clr_sync) state <= ST_CLEAR;
			ST_CLEAR:  if (clr_sync) state <= ST_RELOAD;
			ST_RELOAD: begin
				if (!clr_sync)
					state <= ST_CLEAR;
				else if (reload_d && reload_on && scan_d == 4'hB)
					state <= ST_RUN;
			end
			default:   state <= ST_RUN;
			endcase
		end
	end

	// scan the held data one channel per cycle; read data lag one cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scan       <= 4'h0;
			scan_d     <= 4'h0;
			scan_valid <= 1'b0;
			reload_d   <= 1'b0;
		end else begin
			scan_d     <= scan;
			scan_valid <= 1'b1;
			reload_d   <= (state == ST_RELOAD) && clr_sync;
			scan       <= (scan == 4'hB) ? 4'h0 : scan + 4'h1;
		end
	end

	// reload must sweep from slot 0, else channels below the scan
	// position at release would keep the clear code
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reload_on <= 1'b0;
		end else if (state != ST_RELOAD || !clr_sync) begin
			reload_on <= 1'b0;
		end else if (reload_d && scan_d == 4'h0) begin
			reload_on <= 1'b1;
		end
	end

	// normal load marks channels pending; copy happens during scan
	// trade-off: one word read per cycle costs up to 13 cycles of latency
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_mask <= 12'h000;
		end else if (state != ST_RUN) begin
			pend_mask <= 12'h000;
		end else begin
			if (load_pulse || !sync_load_select)
				pend_mask <= 12'hFFF;
			else if (wr_en && is_chan(wr_addr))
				pend_mask <= pend_mask;
			else if (scan_valid && is_chan(scan_d))
				pend_mask[scan_d] <= 1'b0;
		end
	end

	// output latches: clear code while clear, reload ignores load select
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_flat   <= {`DCA_CHANNELS{`DCA_DATA_RESET}};
			clear_active <= 1'b0;
		end else begin
			clear_active <= (state == ST_CLEAR) || !clr_sync;
			if (!clr_sync) begin
				latch_flat <= {`DCA_CHANNELS{`DCA_CLEAR_CODE}};
			end else if (scan_valid && is_chan(scan_d)) begin
				if (state == ST_RELOAD && reload_d && (reload_on || scan_d == 4'h0))
					latch_flat[scan_d*12 +: 12] <= rd_data;
				else if (state == ST_RUN && pend_mask[scan_d])
					latch_flat[scan_d*12 +: 12] <= rd_data;
			end
		end
	end

	// open drain alarm: data always low, enable low pulls the line
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_out  <= 1'b0;
			alarm_oe_n <= 1'b1;
		end else begin
			alarm_out  <= 1'b0;
			alarm_oe_n <= ~(|out_of_range);
		end
	end
endmodule
`default_nettype wire

//--- tb/dca_ctrl_checker.sv
// port assertions for dca_ctrl
// assumes a bind from tb_top, one clock, async low reset
`default_nettype none
module dca_ctrl_checker (
	input wire logic         clk,
	input wire logic         rst_n,
	input wire logic         converter_clear_n,
	input wire logic [15:0]  out_of_range,
	input wire logic [143:0] latch_flat,
	input wire logic         clear_active,
	input wire logic         alarm_out,
	input wire logic         alarm_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// four samples cover the two-flop sync plus the latch stage
	sequence s_low;
		!converter_clear_n [*4];
	endsequence
	// release needs one more: the state leaves clear a cycle later
	sequence s_high;
		converter_clear_n [*5];
	endsequence
	sequence s_fall;
		$fell(converter_clear_n) ##1 !converter_clear_n ##1 !converter_clear_n;
	endsequence
	a_clear_entry: assert property (s_fall |=> clear_active) else $error("late clear");
	a_clear_code: assert property (s_low |-> latch_flat == '0 && clear_active) else $error("no clear");
	a_normal_run: assert property (s_high |-> !clear_active) else $error("clear stuck");
	a_alarm_low: assert property (|out_of_range |=> !alarm_oe_n) else $error("no alarm");
	a_never_high: assert property (alarm_out == 1'h0) else $error("alarm driven");
	a_alarm_free: assert property (out_of_range == '0 |=> alarm_oe_n) else $error("alarm held");
endmodule
`default_nettype wire

//--- tb/dca_host.sv
// board controller model: clear pin and pulled-up alarm line
// assumes the bench moves want_clear at the falling edge
`default_nettype none
module dca_host (
	input  wire logic want_clear,
	input  wire logic alarm_oe_n,
	input  wire logic alarm_out,
	output wire logic converter_clear_n,
	output wire logic alarm_line
);
	timeunit 1ns;
	timeprecision 1ns;
	// clear is a plain active-low level
	assign converter_clear_n = ~want_clear;
	// pull-up wins whenever the pin is let go
	assign alarm_line = alarm_oe_n ? 1'h1 : alarm_out;
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// bench for dca_ctrl: update, clear, load and alarm
// assumes dca_ctrl and dca_host compiled before
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, clr = 0, wr_en = 0, sel = 0, ld = 0, ca, ao, oe_n;
	logic [3:0] wa = 0;
	logic [11:0] wd = 0;
	logic [15:0] oor = 0;
	logic [143:0] lf, ex = 0;
	wire clr_n, aline;
	int failures = 0, checked = 0, cyc = 0;
	always #20 clk = ~clk;
	dca_host u_dca_host (.want_clear(clr), .alarm_oe_n(oe_n), .alarm_out(ao),
		.converter_clear_n(clr_n), .alarm_line(aline));
	dca_ctrl u_dca_ctrl (.clk, .rst_n, .converter_clear_n(clr_n), .wr_en, .wr_addr(wa),
		.wr_data(wd), .sync_load_select(sel), .load_pulse(ld), .out_of_range(oor),
		.latch_flat(lf), .clear_active(ca), .alarm_out(ao), .alarm_oe_n(oe_n));
	task chk(input logic [143:0] s, e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("unexpected t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	// one-cycle write; slots above 11 must be ignored
	task wr(input int a, input logic [11:0] d);
		@(negedge clk);
		wr_en = 1;
		wa = a[3:0];
		wd = d;
		@(negedge clk) wr_en = 0;
		if (a < 12) ex[12*a +: 12] = d;
	endtask
	task t_norm;
		for (int i = 0; i < 13; i++) wr(i, 12'hA00 + i[11:0]);
		repeat (15) @(negedge clk);
		chk(lf, ex);
		$display("norm end");
	endtask
	// write while cleared, release with select set
	task t_clear;
		clr = 1;
		wr(3, 12'h5C3);
		repeat (4) @(negedge clk);
		chk(lf, '0);
		chk(ca, 1);
		sel = 1;
		clr = 0;
		repeat (30) @(negedge clk);
		chk(lf, ex);
		$display("clear end");
	endtask
	task t_load;
		wr(5, 12'h0F5);
		repeat (15) @(negedge clk);
		chk(lf[71:60], 12'hA05);
		ld = 1;
		@(negedge clk) ld = 0;
		repeat (15) @(negedge clk);
		chk(lf, ex);
		$display("load end");
	endtask
	task t_alarm;
		oor = 16'h8000;
		repeat (2) @(negedge clk);
		chk(aline, 0);
		chk(ao, 0);
		oor = 16'h0000;
		repeat (2) @(negedge clk);
		chk(aline, 1);
		$display("alarm end");
	endtask
	task close_out;
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 400) begin
			failures++;
			close_out;
		end
	end
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1;
		t_norm;
		t_clear;
		t_load;
		t_alarm;
		close_out;
	end
endmodule
bind dca_ctrl dca_ctrl_checker u_chk (.clk, .rst_n, .converter_clear_n, .out_of_range,
	.latch_flat, .clear_active, .alarm_out, .alarm_oe_n);
`default_nettype wire
